// [pkg/ufdma_defs.svh]
`ifndef UFDMA_DEFS_SVH
`define UFDMA_DEFS_SVH

// Register byte offsets
`define UFDMA_OFF_CTRL 8'h00
`define UFDMA_OFF_STATUS 8'h04
`define UFDMA_OFF_ISTAT 8'h08
`define UFDMA_OFF_IMASK 8'h0C
`define UFDMA_OFF_TXDATA 8'h10
`define UFDMA_OFF_RXDATA 8'h14

// Control register fields
`define UFDMA_FC_EN 0
`define UFDMA_FC_RXF 1
`define UFDMA_FC_TXF 2
`define UFDMA_FC_DMA 3
`define UFDMA_FC_TXT_LO 4
`define UFDMA_FC_RXT_LO 6
`define UFDMA_FC_W 8

// Status register fields
`define UFDMA_ST_TXCNT_LO 0
`define UFDMA_ST_RXCNT_LO 8
`define UFDMA_ST_TXREQ 16
`define UFDMA_ST_RXREQ 17
`define UFDMA_ST_EN 18
`define UFDMA_ST_BLOCK 19

// Receive data register fields
`define UFDMA_RXD_VALID 8

// Interrupt status and mask bits
`define UFDMA_IS_TX 0
`define UFDMA_IS_RX 1
`define UFDMA_IS_TMO 2
`define UFDMA_IS_OVR 3
`define UFDMA_IS_W 4

// Trigger thresholds in characters
`define UFDMA_RX_THR0 8
`define UFDMA_RX_THR1 16
`define UFDMA_RX_THR2 56
`define UFDMA_RX_THR3 60
`define UFDMA_TX_THR0 8
`define UFDMA_TX_THR1 16
`define UFDMA_TX_THR2 32
`define UFDMA_TX_THR3 56

// Reset values
`define UFDMA_RST_TRIG 2'h0
`define UFDMA_RST_ISTAT 4'h0
`define UFDMA_RST_IMASK 4'h0
`define UFDMA_RST_WORD 32'h00000000
`define UFDMA_RST_CHAR 8'h00

// Capacity while the FIFOs are disabled: the holding register only
`define UFDMA_HOLD_CAP 1

`endif

// [pkg/ufdma_pkg.sv]
package ufdma_pkg;

  // Block-mode request hysteresis state
  typedef enum logic [1:0] {
    UFDMA_REQ_OFF = 2'b01,
    UFDMA_REQ_ON = 2'b10
  } ufdma_req_type;

endpackage

// [core/ufdma_fifo.sv]
`timescale 1ns/1ps
module ufdma_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  input wire logic flush,
  output logic [WIDTH-1:0] head,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } ufdma_fifo_state_type;

  ufdma_fifo_state_type q;
  ufdma_fifo_state_type d;

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("ufdma_fifo: DEPTH must be a power of two, at least 2");
  end

  // Next state: flush empties the store, full push and empty pop ignored
  always_comb begin
    logic do_push;
    logic do_pop;
    do_push = 1'b0;
    do_pop = 1'b0;
    d = q;
    do_push = push && (q.cnt != (AW+1)'(DEPTH));
    do_pop = pop && (q.cnt != '0);
    if (flush) begin
      d.wr = '0;
      d.rd = '0;
      d.cnt = '0;
    end else begin
      if (do_push) begin
        d.mem[q.wr] = push_data;
        d.wr = q.wr + 1'b1;
      end
      if (do_pop) begin
        d.rd = q.rd + 1'b1;
      end
      if (do_push && !do_pop) begin
        d.cnt = q.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
        d.cnt = q.cnt - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign head = q.mem[q.rd];
  assign count = q.cnt;
endmodule

// [core/ufdma_top.sv]
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ufdma_defs.svh"

module ufdma_top
  import ufdma_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] tx_char,
  output logic tx_char_valid,
  input wire logic tx_char_take,
  input wire logic [7:0] rx_char,
  input wire logic rx_char_valid,
  input wire logic rx_timeout,
  output logic [$clog2(DEPTH):0] tx_fill,
  output logic [$clog2(DEPTH):0] rx_fill,
  output logic fifo_enabled,
  output logic tx_dma_request_n,
  output logic rx_dma_request_n,
  output logic irq
);
  localparam int CW = $clog2(DEPTH) + 1;

  // Every trigger must fit below the depth
  if (DEPTH < 64 || AW < 8) begin : g_bad_param
    $error("ufdma_top: DEPTH must be at least 64 and AW at least 8");
  end

  typedef struct packed {
    logic fen;
    logic dma_block;
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic tx_flush;
    logic rx_flush;
    logic [`UFDMA_IS_W-1:0] istat;
    logic [`UFDMA_IS_W-1:0] imask;
    logic tx_lvl;
    logic rx_lvl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_rd_ok;
    logic [7:0] tx_char;
    logic tx_valid;
    ufdma_req_type tx_st;
    ufdma_req_type rx_st;
    logic tx_req_n;
    logic rx_req_n;
    logic irq;
    logic [CW-1:0] tx_fill;
    logic [CW-1:0] rx_fill;
  } ufdma_top_state_type;

  ufdma_top_state_type q;
  ufdma_top_state_type d;

  logic [7:0] tx_head;
  logic [7:0] rx_head;
  logic [CW-1:0] tx_cnt;
  logic [CW-1:0] rx_cnt;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;

  // Receive trigger decode
  function automatic logic [CW-1:0] rx_thr(input logic [1:0] code);
    unique case (code)
      2'h0: rx_thr = CW'(`UFDMA_RX_THR0);
      2'h1: rx_thr = CW'(`UFDMA_RX_THR1);
      2'h2: rx_thr = CW'(`UFDMA_RX_THR2);
      2'h3: rx_thr = CW'(`UFDMA_RX_THR3);
    endcase
  endfunction

  // Transmit trigger decode
  function automatic logic [CW-1:0] tx_thr(input logic [1:0] code);
    unique case (code)
      2'h0: tx_thr = CW'(`UFDMA_TX_THR0);
      2'h1: tx_thr = CW'(`UFDMA_TX_THR1);
      2'h2: tx_thr = CW'(`UFDMA_TX_THR2);
      2'h3: tx_thr = CW'(`UFDMA_TX_THR3);
    endcase
  endfunction

  // Transmit store, 64 entries by default
  ufdma_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_tx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .push(tx_push),
    .push_data(pwdata[7:0]),
    .pop(tx_pop),
    .flush(q.tx_flush),
    .head(tx_head),
    .count(tx_cnt)
  );

  // Receive store, 64 entries by default
  ufdma_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_rx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .push(rx_push),
    .push_data(rx_char),
    .pop(rx_pop),
    .flush(q.rx_flush),
    .head(rx_head),
    .count(rx_cnt)
  );

  // Next state of the whole block
  always_comb begin
    logic setup;
    logic acc;
    logic wr;
    logic [CW-1:0] cap;
    logic block;
    logic tx_lvl;
    logic rx_lvl;
    logic [`UFDMA_IS_W-1:0] set;
    logic [`UFDMA_IS_W-1:0] clr;
    setup = 1'b0;
    acc = 1'b0;
    wr = 1'b0;
    cap = '0;
    block = 1'b0;
    tx_lvl = 1'b0;
    rx_lvl = 1'b0;
    set = '0;
    clr = '0;
    d = q;
    setup = psel && !penable;
    acc = psel && penable && q.pready;
    wr = acc && pwrite;
    cap = q.fen ? CW'(DEPTH) : CW'(`UFDMA_HOLD_CAP);
    block = q.fen && q.dma_block;

    // Bus side pushes and pops, taken at the access edge
    tx_push = wr && (paddr == `UFDMA_OFF_TXDATA) && (tx_cnt < cap);
    rx_pop = acc && !pwrite && (paddr == `UFDMA_OFF_RXDATA) && q.rx_rd_ok;
    // Line side: drop on overrun, filling goes on to full
    rx_push = rx_char_valid && (rx_cnt < cap);
    // Shift-side output stage refills from the FIFO; not touched by flush
    tx_pop = (!q.tx_valid || tx_char_take) && (tx_cnt != '0);
    if (tx_pop) begin
      d.tx_char = tx_head;
      d.tx_valid = 1'b1;
    end else if (tx_char_take) begin
      d.tx_valid = 1'b0;
    end

    // Flush strobes last one cycle and read back as zero
    d.tx_flush = 1'b0;
    d.rx_flush = 1'b0;
    if (wr && paddr == `UFDMA_OFF_CTRL) begin
      d.fen = pwdata[`UFDMA_FC_EN];
      if (pwdata[`UFDMA_FC_EN]) begin
        d.dma_block = pwdata[`UFDMA_FC_DMA];
        d.tx_trig = pwdata[`UFDMA_FC_TXT_LO +: 2];
        d.rx_trig = pwdata[`UFDMA_FC_RXT_LO +: 2];
        d.tx_flush = pwdata[`UFDMA_FC_TXF];
        d.rx_flush = pwdata[`UFDMA_FC_RXF];
      end
    end
    if (wr && paddr == `UFDMA_OFF_IMASK) begin
      d.imask = pwdata[`UFDMA_IS_W-1:0];
    end

    // Transmit request
    if (!block) begin
      d.tx_st = UFDMA_REQ_OFF;
      d.tx_req_n = (tx_cnt != '0);
    end else begin
      unique case (q.tx_st)
        UFDMA_REQ_OFF: begin
          if (tx_cnt == CW'(DEPTH)) begin
            d.tx_st = UFDMA_REQ_ON;
          end
        end
        UFDMA_REQ_ON: begin
          if (tx_cnt <= tx_thr(q.tx_trig)) begin
            d.tx_st = UFDMA_REQ_OFF;
          end
        end
      endcase
      d.tx_req_n = (d.tx_st == UFDMA_REQ_ON);
    end

    // Receive request
    if (!block) begin
      d.rx_st = UFDMA_REQ_OFF;
      d.rx_req_n = (rx_cnt == '0);
    end else begin
      unique case (q.rx_st)
        UFDMA_REQ_OFF: begin
          if (rx_cnt >= rx_thr(q.rx_trig) || (rx_timeout && rx_cnt != '0)) begin
            d.rx_st = UFDMA_REQ_ON;
          end
        end
        UFDMA_REQ_ON: begin
          if (rx_cnt == '0) begin
            d.rx_st = UFDMA_REQ_OFF;
          end
        end
      endcase
      d.rx_req_n = (d.rx_st == UFDMA_REQ_OFF);
    end

    // Interrupt level conditions and their rising edges
    tx_lvl = block ? (tx_cnt < tx_thr(q.tx_trig)) : (tx_cnt == '0);
    rx_lvl = q.fen ? (rx_cnt >= rx_thr(q.rx_trig)) : (rx_cnt != '0);
    d.tx_lvl = tx_lvl;
    d.rx_lvl = rx_lvl;
    set[`UFDMA_IS_TX] = tx_lvl && !q.tx_lvl;
    set[`UFDMA_IS_RX] = rx_lvl && !q.rx_lvl;
    set[`UFDMA_IS_TMO] = rx_timeout;
    set[`UFDMA_IS_OVR] = rx_char_valid && !rx_push;
    if (wr && paddr == `UFDMA_OFF_ISTAT) begin
      clr = pwdata[`UFDMA_IS_W-1:0];
    end
    // Write-one clear, a new event wins
    d.istat = (q.istat & ~clr) | set;
    d.irq = |(d.istat & d.imask);

    // Bus answer prepared in the setup cycle
    d.pready = setup;
    d.pslverr = 1'b0;
    d.prdata = `UFDMA_RST_WORD;
    d.rx_rd_ok = 1'b0;
    if (setup) begin
      unique case (paddr)
        `UFDMA_OFF_CTRL: begin
          d.prdata[`UFDMA_FC_EN] = q.fen;
          d.prdata[`UFDMA_FC_DMA] = q.dma_block;
          d.prdata[`UFDMA_FC_TXT_LO +: 2] = q.tx_trig;
          d.prdata[`UFDMA_FC_RXT_LO +: 2] = q.rx_trig;
        end
        `UFDMA_OFF_STATUS: begin
          d.prdata[`UFDMA_ST_TXCNT_LO +: CW] = tx_cnt;
          d.prdata[`UFDMA_ST_RXCNT_LO +: CW] = rx_cnt;
          d.prdata[`UFDMA_ST_TXREQ] = q.tx_req_n;
          d.prdata[`UFDMA_ST_RXREQ] = q.rx_req_n;
          d.prdata[`UFDMA_ST_EN] = q.fen;
          d.prdata[`UFDMA_ST_BLOCK] = q.dma_block;
        end
        `UFDMA_OFF_ISTAT: begin
          d.prdata[`UFDMA_IS_W-1:0] = q.istat;
        end
        `UFDMA_OFF_IMASK: begin
          d.prdata[`UFDMA_IS_W-1:0] = q.imask;
        end
        `UFDMA_OFF_TXDATA: begin
          d.prdata = `UFDMA_RST_WORD;
        end
        `UFDMA_OFF_RXDATA: begin
          d.rx_rd_ok = (rx_cnt != '0);
          d.prdata[7:0] = (rx_cnt != '0) ? rx_head : `UFDMA_RST_CHAR;
          d.prdata[`UFDMA_RXD_VALID] = (rx_cnt != '0);
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
    end

    // Fill counts for the rest of the channel
    d.tx_fill = tx_cnt;
    d.rx_fill = rx_cnt;
  end

  // State register with reset defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.fen <= 1'b0;
      q.dma_block <= 1'b0;
      q.rx_trig <= `UFDMA_RST_TRIG;
      q.tx_trig <= `UFDMA_RST_TRIG;
      q.istat <= `UFDMA_RST_ISTAT;
      q.imask <= `UFDMA_RST_IMASK;
      q.tx_lvl <= 1'b1;
      q.tx_st <= UFDMA_REQ_OFF;
      q.rx_st <= UFDMA_REQ_OFF;
      q.tx_req_n <= 1'b0;
      q.rx_req_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign tx_char = q.tx_char;
  assign tx_char_valid = q.tx_valid;
  assign tx_fill = q.tx_fill;
  assign rx_fill = q.rx_fill;
  assign fifo_enabled = q.fen;
  assign tx_dma_request_n = q.tx_req_n;
  assign rx_dma_request_n = q.rx_req_n;
  assign irq = q.irq;
endmodule

// [test/ufdma_asserts.sv]
`timescale 1ns/1ps
module ufdma_asserts #(
  parameter int DEPTH = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] tx_char,
  input wire logic tx_char_valid,
  input wire logic tx_char_take,
  input wire logic [$clog2(DEPTH):0] tx_fill,
  input wire logic [$clog2(DEPTH):0] rx_fill,
  input wire logic fifo_enabled,
  input wire logic tx_dma_request_n,
  input wire logic rx_dma_request_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_next: assert property (s_setup |=> s_access) else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_tx_full_req: assert property ((tx_fill == DEPTH)[*3] |-> tx_dma_request_n)
    else $error("tx request low at full");
  a_tx_empty_req: assert property ((tx_fill == 0)[*3] |-> !tx_dma_request_n)
    else $error("tx request high when empty");
  a_rx_empty_req: assert property ((rx_fill == 0)[*3] |-> rx_dma_request_n)
    else $error("rx request low when empty");
  a_rx_wait_req: assert property ((!fifo_enabled && rx_fill != 0)[*3] |->
    !rx_dma_request_n) else $error("rx request high with data");
  a_stage_hold: assert property (tx_char_valid && !tx_char_take |=>
    tx_char_valid && $stable(tx_char)) else $error("stage lost its character");
  a_fill_limit: assert property (tx_fill <= DEPTH && rx_fill <= DEPTH)
    else $error("fill above capacity");
endmodule
bind ufdma_top ufdma_asserts #(.DEPTH(DEPTH)) u_chk (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .tx_char, .tx_char_valid, .tx_char_take, .tx_fill, .rx_fill,
  .fifo_enabled, .tx_dma_request_n, .rx_dma_request_n);

// [test/ufdma_partner.sv]
`timescale 1ns/1ps
module ufdma_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold,
  input wire logic slow,
  output logic tx_char_take,
  output logic [7:0] rx_char,
  output logic rx_char_valid,
  output logic rx_timeout
);
  logic [1:0] cnt_q;
  // Shifter pace: stalled, every fourth cycle, or every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      tx_char_take <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      tx_char_take <= !hold && (!slow || cnt_q == 2'h3);
    end
  end
  initial begin
    rx_char = 8'hFF;
    rx_char_valid = 1'b0;
    rx_timeout = 1'b0;
  end
  // One character or time-out pulse, then idle data inverted
  task automatic send(input logic t, input logic [7:0] c);
    rx_char <= c;
    rx_char_valid <= !t;
    rx_timeout <= t;
    @(posedge pclk);
    rx_char <= ~c;
    rx_char_valid <= 1'b0;
    rx_timeout <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule

// [test/test_uart_fifo_control_dma_ready.sv]
`timescale 1ns/1ps
module test_uart_fifo_control_dma_ready;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hold, slow;
  logic [7:0] paddr, tx_char, rx_char;
  logic [31:0] pwdata, prdata, rd;
  logic tx_char_valid, tx_char_take, rx_char_valid, rx_timeout, fifo_enabled, irq;
  logic [6:0] tx_fill, rx_fill;
  logic tx_dma_request_n, rx_dma_request_n;
  int fails, num_checks;
  int rxt[4] = '{8, 16, 56, 60};
  int txt[4] = '{8, 16, 32, 56};
  ufdma_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_char, .tx_char_valid, .tx_char_take, .rx_char, .rx_char_valid, .rx_timeout,
    .tx_fill, .rx_fill, .fifo_enabled, .tx_dma_request_n, .rx_dma_request_n, .irq);
  ufdma_partner u_far (.pclk, .presetn, .hold, .slow, .tx_char_take, .rx_char, .rx_char_valid,
    .rx_timeout);
  // Compare and count
  task automatic ck(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // One bus transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // FIFOs off: holding and receiver requests
  task automatic t_single;
    ck(tx_dma_request_n === 1'b0 && rx_dma_request_n === 1'b1, "idle req");
    apb(1'b1, 8'h10, 32'hA1);
    apb(1'b1, 8'h10, 32'hA2);
    // Request is registered from the count, so let it settle
    @(posedge pclk);
    ck(tx_dma_request_n === 1'b1, "tx req not high");
    ck(tx_char_valid === 1'b1 && tx_char === 8'hA1, "stage char");
    hold <= 1'b0;
    repeat (6) @(posedge pclk);
    ck(tx_dma_request_n === 1'b0, "tx req not low");
    hold <= 1'b1;
    u_far.send(1'b0, 8'h5A);
    ck(rx_dma_request_n === 1'b0, "rx req not low");
    apb(1'b0, 8'h14, 32'h0);
    ck(rd[8:0] === 9'h15A, "rx data");
    repeat (2) @(posedge pclk);
    ck(rx_dma_request_n === 1'b1, "rx req not high");
  endtask
  // Control register gating and decode
  task automatic t_regs;
    apb(1'b0, 8'h00, 32'h0);
    ck(rd === 32'h0, "control reset");
    apb(1'b1, 8'h00, 32'hF8);
    apb(1'b0, 8'h00, 32'h0);
    ck(rd === 32'h0 && fifo_enabled === 1'b0, "taken without enable");
    apb(1'b1, 8'h00, 32'h39);
    apb(1'b0, 8'h00, 32'h0);
    ck(rd === 32'h39 && fifo_enabled === 1'b1, "control readback");
    apb(1'b0, 8'h04, 32'h0);
    ck(rd === 32'h000E0000, "status word");
    apb(1'b0, 8'h40, 32'h0);
    ck(err === 1'b1, "unmapped accepted");
  endtask
  // Receive triggers, interrupt, overflow, flush
  task automatic t_rx;
    int i;
    logic [31:0] c;
    apb(1'b1, 8'h0C, 32'h2);
    for (int k = 0; k < 4; k++) begin
      c = 32'h9 | (32'(k) << 6);
      apb(1'b1, 8'h00, c | 32'h2);
      apb(1'b1, 8'h08, 32'hF);
      for (i = 1; i < rxt[k]; i++) u_far.send(1'b0, 8'(i));
      ck(rx_dma_request_n === 1'b1 && irq === 1'b0, "rx early");
      u_far.send(1'b0, 8'h3C);
      ck(rx_dma_request_n === 1'b0 && irq === 1'b1, "rx trigger");
      for (i = rxt[k]; i < 66; i++) u_far.send(1'b0, 8'h3C);
      ck(rx_fill === 7'h40, "rx not full");
      apb(1'b0, 8'h08, 32'h0);
      ck(rd[3] === 1'b1 && rd[1] === 1'b1, "rx events");
      apb(1'b1, 8'h00, c | 32'h2);
      apb(1'b1, 8'h08, 32'hF);
      apb(1'b0, 8'h00, 32'h0);
      ck(rd === c && rx_fill === 7'h00 && irq === 1'b0, "rx flush");
      ck(rx_dma_request_n === 1'b1, "rx req after flush");
    end
  endtask
  // Transmit triggers, full hysteresis, flush
  task automatic t_tx;
    int i;
    logic [31:0] c;
    for (int k = 0; k < 4; k++) begin
      c = 32'h9 | (32'(k) << 4);
      apb(1'b1, 8'h00, c | 32'h4);
      for (i = 0; i < 65; i++) apb(1'b1, 8'h10, 32'(i));
      apb(1'b1, 8'h08, 32'hF);
      ck(tx_fill === 7'h40 && tx_dma_request_n === 1'b1, "tx full");
      slow <= 1'b1;
      hold <= 1'b0;
      for (i = 0; i < 999 && tx_dma_request_n !== 1'b0; i++) @(posedge pclk);
      ck(tx_fill === 7'(txt[k]), "tx req low fill");
      for (i = 0; i < 99 && tx_fill >= 7'(txt[k]); i++) @(posedge pclk);
      hold <= 1'b1;
      apb(1'b0, 8'h08, 32'h0);
      ck(rd[0] === 1'b1, "tx level event");
      apb(1'b1, 8'h00, c | 32'h4);
      apb(1'b0, 8'h00, 32'h0);
      ck(rd === c && tx_fill === 7'h00 && tx_char_valid === 1'b1, "tx flush");
    end
  endtask
  // Time-out below trigger
  task automatic t_tmo;
    apb(1'b1, 8'h00, 32'hC9);
    u_far.send(1'b0, 8'h11);
    ck(rx_dma_request_n === 1'b1, "rx req early");
    u_far.send(1'b1, 8'h00);
    ck(rx_dma_request_n === 1'b0, "rx req timeout");
    apb(1'b0, 8'h08, 32'h0);
    ck(rd[2] === 1'b1, "timeout event");
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Watchdog
  initial begin
    #2000000;
    fails++;
    conclude;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hold = 1'b1;
    slow = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_single;
    t_regs;
    t_rx;
    t_tx;
    t_tmo;
    conclude;
  end
endmodule
